// *** rtl/address_decode.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "task_file_defines.svh"
module address_decode
  import task_file_pkg::*;
(
  task_file_if.decoder tf
);
  // Mode select and field split of the starting address.
  assign tf.lba_mode = tf.dev_sel[`DEVSEL_LBA_BIT]; // [R15]
  assign tf.start_addr = {tf.dev_sel[3:0], tf.addr_high, tf.addr_mid, tf.addr_low}; // [R16]
  assign tf.head = tf.dev_sel[3:0]; // [R16]
  assign tf.cylinder = {tf.addr_high, tf.addr_mid}; // [R13]
  assign tf.sector = tf.addr_low; // [R12]
endmodule
`default_nettype wire

// *** rtl/ata_task_file_registers.sv ***
// Function
// [R01] A 16-bit data port moves blocks between sector buffer and host.
// [R02] Error cause detail is meaningful only while status error bit is set.
// [R03] Bad block detection sets error cause bit 7.
// [R04] Uncorrectable data error sets error cause bit 6.
// [R05] Missing or invalid sector identifier sets error cause bit 4.
// [R06] Aborted or invalid command sets error cause bit 2.
// [R07] General error sets error cause bit 0.
// [R08] Error cause bits 5, 3 and 1 always read zero.
// [R09] A transfer length of zero means 256 sectors.
// [R10] Successful completion leaves the transfer length at zero.
// [R11] Failed completion leaves the remaining sector count in transfer length.
// [R12] Low byte is sector number in CHS, block address 7-0 in LBA.
// [R13] Middle byte is cylinder low, block address 15-8 in LBA.
// [R14] High byte is cylinder high, block address 23-16 in LBA.
// [R15] Device select bit 6 chooses CHS when 0, block addressing when 1.
// [R16] Device select bits 3-0 are head number or block address 27-24.
// [R17] Device select bits 7 and 5 read fixed at one.
// [R18] Host always writes zero to the drive number bit.
// [R19] Only a single device answers per channel; no primary or secondary.
// [R20] No alternate status register exists in the task file.
// [R21] Task file values travel in frame structure fields in legacy mode.
// [R22] Status error bit is set when the previous command ended in error.
`timescale 1ns/100ps
`default_nettype none
`include "task_file_defines.svh"
module ata_task_file_registers
  import task_file_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic fis_wr,
  input wire logic fis_rd,
  input wire logic [2:0] fis_sel,
  input wire logic [15:0] fis_wdata,
  output logic [15:0] fis_rdata,
  output logic fis_rvalid,
  input wire logic cmd_start,
  input wire logic sector_done,
  input wire logic cmd_end,
  input wire logic cmd_fail,
  input wire logic bad_block_flag,
  input wire logic uncorrectable_flag,
  input wire logic sector_id_missing_flag,
  input wire logic command_aborted_flag,
  input wire logic general_error_flag,
  input wire logic buf_wr,
  input wire logic [15:0] buf_wdata,
  output logic [15:0] buf_rdata,
  output logic buf_rd_valid,
  output logic cmd_busy,
  output logic [8:0] sectors_left,
  output logic lba_mode,
  output logic [27:0] start_addr,
  output logic [3:0] head,
  output logic [15:0] cylinder,
  output logic [7:0] sector,
  output logic [7:0] feature_out
);
  task_file_if tf ();
  address_decode u_decode (.tf(tf));

  logic [15:0] data_q;
  logic [7:0] error_q, error_d;
  logic [7:0] feature_q;
  logic [7:0] length_q, length_d;
  logic [7:0] addr_low_q, addr_mid_q, addr_high_q;
  logic [7:0] dev_sel_q;
  logic status_err_q, status_err_d;
  logic [8:0] left_q, left_d;
  cmd_state_e state_q, state_d;
  logic [15:0] rdata_d;
  logic [15:0] fis_rdata_q;
  logic fis_rvalid_q;
  logic [15:0] buf_rdata_q;
  logic buf_rd_valid_q;
  logic [27:0] start_addr_q;
  logic [3:0] head_q;
  logic [15:0] cylinder_q;
  logic [7:0] sector_q;
  logic lba_q;
  logic busy_q;

  function automatic logic sel_hit(input logic [2:0] s, input logic [2:0] want);
    sel_hit = (s == want);
  endfunction

  // Writes other than to the data port are refused while a command runs so the address stays stable.
  wire host_wr = fis_wr && (state_q != CMD_RUN); // [R21]
  wire wr_data = fis_wr && sel_hit(fis_sel, `TF_SEL_DATA); // [R01]
  wire wr_feature = host_wr && sel_hit(fis_sel, `TF_SEL_ERROR_FEATURE);
  wire wr_length = host_wr && sel_hit(fis_sel, `TF_SEL_LENGTH);
  wire wr_low = host_wr && sel_hit(fis_sel, `TF_SEL_ADDR_LOW);
  wire wr_mid = host_wr && sel_hit(fis_sel, `TF_SEL_ADDR_MID);
  wire wr_high = host_wr && sel_hit(fis_sel, `TF_SEL_ADDR_HIGH);
  wire wr_devsel = host_wr && sel_hit(fis_sel, `TF_SEL_DEVSEL);
  wire rd_data = fis_rd && sel_hit(fis_sel, `TF_SEL_DATA);

  // Drive number is ignored; one device per channel always answers.
  wire [7:0] devsel_wr = (fis_wdata[7:0] & `DEVSEL_WRITE_MASK
    & ~(8'h01 << `DEVSEL_DRIVE_BIT)) | `DEVSEL_FIXED_MASK; // [R17] [R18] [R19]

  // Error cause gathers events during a run; reserved bits stay zero.
  wire [7:0] err_events = {bad_block_flag, uncorrectable_flag, 1'b0,
    sector_id_missing_flag, 1'b0, command_aborted_flag, 1'b0,
    general_error_flag}; // [R03] [R04] [R05] [R06] [R07] [R08]
  wire any_err = (|err_events) || cmd_fail || (|error_q);

  wire [8:0] length_req = (length_q == `LENGTH_ZERO) ? `FULL_LENGTH : {1'b0, length_q}; // [R09]

  always_comb begin
    state_d = state_q;
    left_d = left_q;
    length_d = wr_length ? fis_wdata[7:0] : length_q;
    error_d = error_q;
    status_err_d = status_err_q;
    unique case (state_q)
      CMD_IDLE, CMD_DONE: begin
        if (cmd_start) begin
          state_d = CMD_RUN;
          left_d = length_req;
          error_d = `BYTE_RESET;
          status_err_d = 1'b0;
        end
      end
      CMD_RUN: begin
        error_d = error_q | err_events;
        if (sector_done && left_q != 9'h000) begin
          left_d = left_q - 9'h001;
        end
        if (cmd_end) begin
          state_d = CMD_DONE;
          status_err_d = any_err; // [R22]
          if (any_err) begin
            length_d = (sector_done && left_q != 9'h000) ? left_d[7:0] : left_q[7:0]; // [R11]
          end else begin
            length_d = `LENGTH_ZERO; // [R10]
          end
        end
      end
    endcase
  end

  // Error detail is shown only while the status error bit is set.
  wire [7:0] error_view = status_err_q ? error_q : `BYTE_RESET; // [R02]

  // No alternate status exists; status select returns only the status error bit, in bit 0.
  always_comb begin
    rdata_d = `WORD_RESET;
    unique case (fis_sel)
      `TF_SEL_DATA: rdata_d = data_q;
      `TF_SEL_ERROR_FEATURE: rdata_d = {8'h00, error_view};
      `TF_SEL_LENGTH: rdata_d = {8'h00, length_q};
      `TF_SEL_ADDR_LOW: rdata_d = {8'h00, addr_low_q};
      `TF_SEL_ADDR_MID: rdata_d = {8'h00, addr_mid_q};
      `TF_SEL_ADDR_HIGH: rdata_d = {8'h00, addr_high_q};
      `TF_SEL_DEVSEL: rdata_d = {8'h00, dev_sel_q};
      `TF_SEL_STATUS: rdata_d = {15'h0, status_err_q}; // [R20]
    endcase
  end

  assign tf.dev_sel = dev_sel_q;
  assign tf.addr_low = addr_low_q;
  assign tf.addr_mid = addr_mid_q;
  assign tf.addr_high = addr_high_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= CMD_IDLE;
      busy_q <= 1'b0;
      left_q <= 9'h000;
      length_q <= `BYTE_RESET;
      error_q <= `BYTE_RESET;
      status_err_q <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q <= (state_d == CMD_RUN);
      left_q <= left_d;
      length_q <= length_d;
      error_q <= error_d;
      status_err_q <= status_err_d;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      feature_q <= `BYTE_RESET;
      addr_low_q <= `BYTE_RESET;
      addr_mid_q <= `BYTE_RESET;
      addr_high_q <= `BYTE_RESET;
      dev_sel_q <= `DEVSEL_RESET;
    end else begin
      if (wr_feature) feature_q <= fis_wdata[7:0];
      if (wr_low) addr_low_q <= fis_wdata[7:0]; // [R12]
      if (wr_mid) addr_mid_q <= fis_wdata[7:0]; // [R13]
      if (wr_high) addr_high_q <= fis_wdata[7:0]; // [R14]
      if (wr_devsel) dev_sel_q <= devsel_wr; // [R15] [R16]
    end
  end

  // Data port: host writes go to the buffer side, buffer writes to the host.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      data_q <= `WORD_RESET;
      buf_rdata_q <= `WORD_RESET;
      buf_rd_valid_q <= 1'b0;
    end else begin
      buf_rd_valid_q <= wr_data; // [R01]
      if (wr_data) begin
        data_q <= fis_wdata;
        buf_rdata_q <= fis_wdata;
      end else if (buf_wr) begin
        data_q <= buf_wdata; // [R01]
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fis_rdata_q <= `WORD_RESET;
      fis_rvalid_q <= 1'b0;
      start_addr_q <= 28'h000_0000;
      head_q <= 4'h0;
      cylinder_q <= `WORD_RESET;
      sector_q <= `BYTE_RESET;
      lba_q <= 1'b0;
    end else begin
      fis_rvalid_q <= fis_rd;
      if (fis_rd) fis_rdata_q <= rdata_d;
      start_addr_q <= tf.start_addr;
      head_q <= tf.head;
      cylinder_q <= tf.cylinder;
      sector_q <= tf.sector;
      lba_q <= tf.lba_mode;
    end
  end

  logic unused_rd;
  assign unused_rd = rd_data;

  assign fis_rdata = fis_rdata_q;
  assign fis_rvalid = fis_rvalid_q;
  assign buf_rdata = buf_rdata_q;
  assign buf_rd_valid = buf_rd_valid_q;
  assign cmd_busy = busy_q;
  assign sectors_left = left_q;
  assign lba_mode = lba_q;
  assign start_addr = start_addr_q;
  assign head = head_q;
  assign cylinder = cylinder_q;
  assign sector = sector_q;
  assign feature_out = feature_q;
endmodule
`default_nettype wire

// *** rtl/task_file_defines.svh ***
`ifndef TASK_FILE_DEFINES_SVH
`define TASK_FILE_DEFINES_SVH
`define TF_SEL_DATA 3'h0
`define TF_SEL_ERROR_FEATURE 3'h1
`define TF_SEL_LENGTH 3'h2
`define TF_SEL_ADDR_LOW 3'h3
`define TF_SEL_ADDR_MID 3'h4
`define TF_SEL_ADDR_HIGH 3'h5
`define TF_SEL_DEVSEL 3'h6
`define TF_SEL_STATUS 3'h7
`define ERR_BAD_BLOCK_BIT 7
`define ERR_UNCORRECTABLE_BIT 6
`define ERR_ID_MISSING_BIT 4
`define ERR_ABORTED_BIT 2
`define ERR_GENERAL_BIT 0
`define STATUS_ERROR_BIT 0
`define DEVSEL_LBA_BIT 6
`define DEVSEL_DRIVE_BIT 4
`define DEVSEL_FIXED_MASK 8'hA0
`define DEVSEL_WRITE_MASK 8'h5F
`define DEVSEL_RESET 8'hA0
`define BYTE_RESET 8'h00
`define WORD_RESET 16'h0000
`define FULL_LENGTH 9'h100
`define LENGTH_ZERO 8'h00
`endif

// *** rtl/task_file_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface task_file_if;
  logic [7:0] dev_sel;
  logic [7:0] addr_low;
  logic [7:0] addr_mid;
  logic [7:0] addr_high;
  logic lba_mode;
  logic [27:0] start_addr;
  logic [3:0] head;
  logic [15:0] cylinder;
  logic [7:0] sector;
  modport decoder (input dev_sel, addr_low, addr_mid, addr_high,
    output lba_mode, start_addr, head, cylinder, sector);
  modport user (output dev_sel, addr_low, addr_mid, addr_high,
    input lba_mode, start_addr, head, cylinder, sector);
endinterface
`default_nettype wire

// *** rtl/task_file_pkg.sv ***
package task_file_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [27:0] block_addr_t;
  typedef enum logic [2:0] {
    CMD_IDLE = 3'b001,
    CMD_RUN = 3'b010,
    CMD_DONE = 3'b100
  } cmd_state_e;
endpackage

// *** tb/ata_task_file_registers_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module ata_task_file_registers_bench;
  import task_file_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic fis_wr, fis_rd, fis_rvalid, cmd_busy, lba_mode, buf_rd_valid, ok;
  logic cmd_start = 1'b0, sector_done = 1'b0, cmd_end = 1'b0, cmd_fail = 1'b0, buf_wr = 1'b0;
  logic bad_block_flag = 1'b0, uncorrectable_flag = 1'b0, sector_id_missing_flag = 1'b0;
  logic command_aborted_flag = 1'b0, general_error_flag = 1'b0;
  logic [2:0] fis_sel;
  logic [15:0] fis_wdata, fis_rdata, buf_rdata, cylinder, rd, buf_wdata = 16'h0000;
  logic [8:0] sectors_left;
  logic [27:0] start_addr;
  logic [3:0] head;
  logic [7:0] sector, feature_out;
  int fails = 0;
  int tests_run = 0;
  always #50 core_clk = ~core_clk;
  ata_task_file_registers u_ata_task_file_registers (.core_clk, .reset, .fis_wr, .fis_rd,
    .fis_sel, .fis_wdata, .fis_rdata, .fis_rvalid, .cmd_start, .sector_done, .cmd_end,
    .cmd_fail, .bad_block_flag, .uncorrectable_flag, .sector_id_missing_flag,
    .command_aborted_flag, .general_error_flag, .buf_wr, .buf_wdata, .buf_rdata,
    .buf_rd_valid, .cmd_busy, .sectors_left, .lba_mode, .start_addr, .head, .cylinder,
    .sector, .feature_out);
  sata_host_model u_sata_host_model (.core_clk, .fis_wr, .fis_rd, .fis_sel, .fis_wdata,
    .fis_rdata, .fis_rvalid);
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [2:0] sel, input logic [15:0] exp);
    u_sata_host_model.get(sel, rd, ok);
    if (!ok) begin
      fails++;
      close_out();
    end else begin
      chk(sel == 3'h0 ? rd : {8'h00, rd[7:0]}, exp);
    end
  endtask
  task automatic ctl(input logic [3:0] c, input logic [4:0] f);
    @(posedge core_clk);
    {cmd_start, sector_done, cmd_end, cmd_fail} <= c;
    {bad_block_flag, uncorrectable_flag, sector_id_missing_flag} <= f[4:2];
    {command_aborted_flag, general_error_flag} <= f[1:0];
    @(posedge core_clk);
    {cmd_start, sector_done, cmd_end, cmd_fail} <= 4'h0;
    {bad_block_flag, uncorrectable_flag, sector_id_missing_flag} <= 3'h0;
    {command_aborted_flag, general_error_flag} <= 2'h0;
    #10;
  endtask
  task automatic t_reset;
    rchk(3'h6, 16'h00a0);
    rchk(3'h1, 16'h0000);
    rchk(3'h7, 16'h0000);
    $display("reset test done");
  endtask
  task automatic t_addr;
    u_sata_host_model.put(3'h6, 16'h0003);
    u_sata_host_model.put(3'h3, 16'h0012);
    u_sata_host_model.put(3'h4, 16'h0034);
    u_sata_host_model.put(3'h5, 16'h0056);
    repeat (2) @(posedge core_clk);
    #10;
    chk({15'h0000, lba_mode}, 16'h0000);
    chk({12'h000, head}, 16'h0003);
    chk(cylinder, 16'h5634);
    chk({8'h00, sector}, 16'h0012);
    u_sata_host_model.put(3'h6, 16'h005f);
    repeat (2) @(posedge core_clk);
    #10;
    chk({15'h0000, lba_mode}, 16'h0001);
    chk(start_addr[15:0], 16'h3412);
    chk({4'h0, start_addr[27:16]}, 16'h0f56);
    rchk(3'h6, 16'h00ef);
    u_sata_host_model.put(3'h1, 16'h005a);
    @(posedge core_clk);
    #10;
    chk({8'h00, feature_out}, 16'h005a);
    $display("address test done");
  endtask
  task automatic t_fail;
    u_sata_host_model.put(3'h2, 16'h0000);
    ctl(4'h8, 5'h00);
    chk({7'h00, sectors_left}, 16'h0100);
    repeat (3) ctl(4'h4, 5'h00);
    ctl(4'h0, 5'h1f);
    ctl(4'h3, 5'h00);
    rchk(3'h2, 16'h00fd);
    rchk(3'h7, 16'h0001);
    rchk(3'h1, 16'h00d5);
    $display("failed command test done");
  endtask
  task automatic t_ok;
    u_sata_host_model.put(3'h2, 16'h0002);
    ctl(4'h8, 5'h00);
    u_sata_host_model.put(3'h3, 16'h0099);
    repeat (2) ctl(4'h4, 5'h00);
    ctl(4'h2, 5'h00);
    rchk(3'h2, 16'h0000);
    rchk(3'h7, 16'h0000);
    rchk(3'h1, 16'h0000);
    rchk(3'h3, 16'h0012);
    $display("good command test done");
  endtask
  task automatic t_data;
    int n;
    ok = 1'b0;
    u_sata_host_model.put(3'h0, 16'ha5c3);
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge core_clk);
      ok = (buf_rd_valid === 1'b1);
    end
    chk(ok ? buf_rdata : 16'h0000, 16'ha5c3);
    if (!ok) begin
      close_out();
    end
    buf_wr <= 1'b1;
    buf_wdata <= 16'h3c5a;
    @(posedge core_clk);
    buf_wr <= 1'b0;
    buf_wdata <= 16'hc3a5;
    rchk(3'h0, 16'h3c5a);
    $display("data port test done");
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_addr();
    t_fail();
    t_ok();
    t_data();
    close_out();
  end
endmodule
`default_nettype wire

// *** tb/sata_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module sata_host_model (
  input wire logic core_clk,
  output logic fis_wr = 1'b0,
  output logic fis_rd = 1'b0,
  output logic [2:0] fis_sel = 3'h0,
  output logic [15:0] fis_wdata = 16'h0000,
  input wire logic [15:0] fis_rdata,
  input wire logic fis_rvalid
);
  // Each register update travels as one field of a host frame.
  task automatic put(input logic [2:0] sel, input logic [15:0] data);
    @(posedge core_clk);
    fis_wr <= 1'b1;
    fis_sel <= sel;
    fis_wdata <= (sel == 3'h6) ? (data & 16'hffef) : data;
    @(posedge core_clk);
    fis_wr <= 1'b0;
    fis_wdata <= ~data;
  endtask
  task automatic get(input logic [2:0] sel, output logic [15:0] data, output logic ok);
    int n;
    ok = 1'b0;
    data = 16'h0000;
    @(posedge core_clk);
    fis_rd <= 1'b1;
    fis_sel <= sel;
    @(posedge core_clk);
    fis_rd <= 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge core_clk);
      if (fis_rvalid === 1'b1) begin
        ok = 1'b1;
        data = fis_rdata;
      end
    end
  endtask
endmodule
`default_nettype wire

// *** tb/task_file_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module task_file_chk (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic fis_wr,
  input wire logic fis_rd,
  input wire logic [2:0] fis_sel,
  input wire logic [15:0] fis_wdata,
  input wire logic [15:0] fis_rdata,
  input wire logic fis_rvalid,
  input wire logic cmd_start,
  input wire logic sector_done,
  input wire logic cmd_end,
  input wire logic cmd_busy,
  input wire logic [8:0] sectors_left,
  input wire logic lba_mode,
  input wire logic [3:0] head,
  input wire logic [7:0] sector
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  logic wr_ok;
  assign wr_ok = fis_wr && !cmd_busy;
  read_answer_a: assert property (fis_rd |=> fis_rvalid)
    else $error("read not answered");
  start_busy_a: assert property (
    cmd_start && !cmd_busy |=> cmd_busy && sectors_left != 9'h000)
    else $error("start did not load a count");
  count_down_a: assert property (
    cmd_busy && sector_done && !cmd_end && sectors_left != 9'h000
    |=> sectors_left == $past(sectors_left) - 9'h001)
    else $error("sector count did not step down");
  low_decode_a: assert property (
    wr_ok && fis_sel == 3'h3 |-> ##2 lba_mode || sector == $past(fis_wdata[7:0], 2))
    else $error("sector number not decoded");
  lba_select_a: assert property (
    wr_ok && fis_sel == 3'h6 |-> ##2 lba_mode == $past(fis_wdata[6], 2))
    else $error("address mode not decoded");
  head_decode_a: assert property (
    wr_ok && fis_sel == 3'h6 && !fis_wdata[6] |-> ##2 head == $past(fis_wdata[3:0], 2))
    else $error("head number not decoded");
  devsel_fixed_a: assert property (
    fis_rd && fis_sel == 3'h6 |=> fis_rdata[7] && fis_rdata[5] && !fis_rdata[4])
    else $error("device select fixed bits wrong");
  error_zero_a: assert property (
    fis_rd && fis_sel == 3'h1 |=> !(fis_rdata[5] || fis_rdata[3] || fis_rdata[1]))
    else $error("error cause spare bits set");
endmodule
bind ata_task_file_registers task_file_chk u_task_file_chk (.core_clk, .reset, .fis_wr,
  .fis_rd, .fis_sel, .fis_wdata, .fis_rdata, .fis_rvalid, .cmd_start, .sector_done,
  .cmd_end, .cmd_busy, .sectors_left, .lba_mode, .head, .sector);
`default_nettype wire
